/* hw/scag_core.sv */
// scag_core: effective-address generation, working registers, software stack checks
// assumes the decoder gives at most one request per cycle and the trap logic takes resp_o
// Summary of operation
// RULE1 - stack pointer addresses next free word; stack grows upward
// RULE2 - push writes then increments pointer; pop decrements pointer then reads
// RULE3 - call pushes upper program counter word with high byte cleared
// RULE4 - exception push puts status low byte above program counter high byte
// RULE5 - upper limit has no reset value; its bit 0 is forced zero
// RULE6 - stack addresses compared with limit; push at limit ok, next push traps
// RULE7 - stack address below 0x0800 raises underflow trap
// RULE8 - software avoids limit write directly followed by stack-pointer indirect read
// RULE9 - secure ram segments reachable only from matching code segment when enabled
// RULE10 - file register instructions use 13-bit direct address, lowest 8192 bytes
// RULE11 - file results go to file register or default register; multiply to pair
// RULE12 - move instruction may address whole data space
// RULE13 - three-operand first operand is direct register; second register, memory or literal
// RULE14 - direct, indirect, post-, pre-modified, 5-bit and 10-bit literal forms supported
// RULE15 - post-modified uses pointer as address, then steps pointer by constant
// RULE16 - pre-modified adjusts pointer by signed constant, uses result as address
// RULE17 - indexed address is pointer plus base operand register
// RULE18 - literal-offset address is pointer plus instruction literal
// RULE19 - move and accumulator add indexed, literal offset, 8-bit and 16-bit literals
// RULE20 - move source and destination share one 4-bit register offset field
// RULE21 - stack error flagged in same cycle as offending address
`timescale 1ns/100ps
module scag_core (
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    input  wire scag_pkg::scag_req_t  req_i,
    input  wire scag_pkg::scag_prot_t prot_i,
    output scag_pkg::scag_resp_t      resp_o,
    output logic [15:0]               stack_pointer_reg_o
);

    // ==================================================
    // state
    typedef struct packed {
        logic [15:0][15:0]    default_working_reg;
        logic [15:0]          stack_upper_limit;
        scag_pkg::scag_resp_t resp;
    } scag_state_t;

    scag_state_t st;
    scag_state_t next_st;

    // ==================================================
    // helpers
    function automatic logic stack_over_limit(input logic [15:0] ea, input logic [15:0] lim);
        stack_over_limit = ea > lim; // see RULE6
    endfunction

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [15:0] lit_ext(input scag_pkg::scag_lit_t k, input logic [15:0] v);
        unique case (k)
            scag_pkg::LIT_5:  lit_ext = {11'h000, v[4:0]};
            scag_pkg::LIT_8:  lit_ext = {8'h00, v[7:0]};
            scag_pkg::LIT_10: lit_ext = {6'h00, v[9:0]};
            scag_pkg::LIT_16: lit_ext = v;
        endcase
    endfunction

    // ==================================================
    // next state
    logic [15:0] ptr_val;
    logic [15:0] base_val;
    logic [15:0] sp_val;
    logic        mem_acc;
    logic        uses_sp;
    logic        deny;

    always_comb begin
        next_st = st;
        next_st.resp = '0;
        ptr_val  = st.default_working_reg[req_i.pointer_reg];
        base_val = st.default_working_reg[req_i.base_operand_reg]; // see RULE20
        sp_val   = st.default_working_reg[scag_pkg::SP_INDEX];
        mem_acc  = 1'b0;
        uses_sp  = 1'b0;
        deny     = 1'b0;
        if (req_i.valid) begin
            next_st.resp.valid   = 1'b1;
            next_st.resp.op1_reg = req_i.base_operand_reg; // see RULE13
            next_st.resp.wdata   = req_i.wdata;
            next_st.resp.dest    = req_i.to_default_working_reg ? scag_pkg::DEST_DEFAULT_WORKING_REG : scag_pkg::DEST_REG;
            unique case (req_i.op)
                scag_pkg::OP_FILE: begin
                    mem_acc = 1'b1;
                    if (req_i.move_instr) begin
                        next_st.resp.effective_address = req_i.full_addr; // see RULE12
                    end else begin
                        next_st.resp.effective_address = {3'h0, req_i.file_addr}; // see RULE10
                    end
                    if (req_i.multiply_instr) begin
                        next_st.resp.dest = scag_pkg::DEST_REG_PAIR; // see RULE11
                    end else if (req_i.to_default_working_reg) begin
                        next_st.resp.dest    = scag_pkg::DEST_DEFAULT_WORKING_REG;
                        next_st.resp.op1_reg = scag_pkg::DEFAULT_DEFAULT_WORKING_REG;
                    end else begin
                        next_st.resp.dest = scag_pkg::DEST_FILE;
                    end
                end
                scag_pkg::OP_REG_DIRECT: begin
                    next_st.resp.operand = ptr_val; // see RULE14
                end
                scag_pkg::OP_IND: begin
                    mem_acc = 1'b1;
                    next_st.resp.effective_address = ptr_val; // see RULE14
                end
                scag_pkg::OP_POST: begin
                    mem_acc = 1'b1;
                    next_st.resp.effective_address = ptr_val; // see RULE15
                    next_st.default_working_reg[req_i.pointer_reg] = ptr_val + req_i.offset;
                end
                scag_pkg::OP_PRE: begin
                    mem_acc = 1'b1;
                    next_st.resp.effective_address = ptr_val + req_i.offset; // see RULE16
                    next_st.default_working_reg[req_i.pointer_reg] = ptr_val + req_i.offset;
                end
                scag_pkg::OP_INDEXED: begin
                    mem_acc = 1'b1;
                    next_st.resp.effective_address = ptr_val + base_val; // see RULE17 see RULE19
                end
                scag_pkg::OP_LIT_OFFSET: begin
                    mem_acc = 1'b1;
                    next_st.resp.effective_address = ptr_val + req_i.offset; // see RULE18 see RULE19
                end
                scag_pkg::OP_LITERAL: begin
                    next_st.resp.operand = lit_ext(req_i.lit_kind, req_i.literal); // see RULE14 see RULE19
                end
                scag_pkg::OP_PUSH, scag_pkg::OP_CALL_PUSH, scag_pkg::OP_EXC_PUSH: begin
                    mem_acc = 1'b1;
                    uses_sp = 1'b1;
                    next_st.resp.wr = 1'b1;
                    next_st.resp.effective_address = sp_val; // see RULE1
                    next_st.default_working_reg[scag_pkg::SP_INDEX] = sp_val + scag_pkg::STACK_STEP; // see RULE2
                    if (req_i.op == scag_pkg::OP_CALL_PUSH) begin
                        next_st.resp.wdata = {scag_pkg::ZERO_BYTE, req_i.pc_upper[7:0]}; // see RULE3
                    end else if (req_i.op == scag_pkg::OP_EXC_PUSH) begin
                        next_st.resp.wdata = {req_i.status_low_byte, req_i.pc_upper[7:0]}; // see RULE4
                    end
                end
                scag_pkg::OP_POP: begin
                    mem_acc = 1'b1;
                    uses_sp = 1'b1;
                    next_st.resp.rd = 1'b1;
                    next_st.resp.effective_address = sp_val - scag_pkg::STACK_STEP; // see RULE2
                    next_st.default_working_reg[scag_pkg::SP_INDEX] = sp_val - scag_pkg::STACK_STEP;
                end
                scag_pkg::OP_WR_LIMIT: begin
                    next_st.stack_upper_limit = req_i.wdata & scag_pkg::WORD_MASK; // see RULE5
                end
                scag_pkg::OP_WR_REG: begin
                    next_st.default_working_reg[req_i.pointer_reg] = req_i.wdata;
                end
                default: begin
                    next_st.resp.valid = 1'b0;
                end
            endcase
            if (mem_acc && !uses_sp) begin
                next_st.resp.rd = !req_i.is_write;
                next_st.resp.wr = req_i.is_write;
                uses_sp = (req_i.pointer_reg == scag_pkg::SP_INDEX) && (req_i.op != scag_pkg::OP_FILE);
            end
            if (mem_acc && uses_sp) begin
                // limit written last cycle is already in effect; see RULE8
                next_st.resp.stack_over  = stack_over_limit(next_st.resp.effective_address,
                                                            st.stack_upper_limit); // see RULE6 see RULE21
                next_st.resp.stack_under = next_st.resp.effective_address < scag_pkg::STACK_FLOOR; // see RULE7
            end
            if (mem_acc) begin
                deny = (prot_i.boot_ram_en
                        && in_range(next_st.resp.effective_address, scag_pkg::BOOT_RAM_LO, scag_pkg::BOOT_RAM_HI)
                        && prot_i.code_seg != scag_pkg::SEG_BOOT)
                    || (prot_i.sec_ram_en
                        && in_range(next_st.resp.effective_address, scag_pkg::SEC_RAM_LO, scag_pkg::SEC_RAM_HI)
                        && prot_i.code_seg != scag_pkg::SEG_SEC); // see RULE9
                if (deny) begin
                    next_st.resp.rd         = 1'b0;
                    next_st.resp.wr         = 1'b0;
                    next_st.resp.prot_fault = 1'b1;
                end
            end
        end
    end

    // ==================================================
    // registers; limit keeps its value through reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st.default_working_reg                   <= '0;
            st.default_working_reg[scag_pkg::SP_INDEX] <= scag_pkg::SP_RESET;
            st.resp                   <= '0;
        end else begin
            st <= next_st; // see RULE5
        end
    end

    assign resp_o              = st.resp;
    assign stack_pointer_reg_o = st.default_working_reg[scag_pkg::SP_INDEX];

    // ==================================================
    // checks
    logic is_push;
    logic is_pop;
    assign is_push = req_i.valid && (req_i.op == scag_pkg::OP_PUSH);
    assign is_pop  = req_i.valid && (req_i.op == scag_pkg::OP_POP);

    sequence push_at_limit;
        is_push && (st.default_working_reg[scag_pkg::SP_INDEX] == st.stack_upper_limit)
        && (st.stack_upper_limit >= scag_pkg::STACK_FLOOR) && !prot_i.boot_ram_en && !prot_i.sec_ram_en;
    endsequence

    sequence push_past_limit;
        is_push && (st.default_working_reg[scag_pkg::SP_INDEX] > st.stack_upper_limit);
    endsequence

    AST_PUSH_STEP: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE2
        is_push |=> resp_o.wr && resp_o.effective_address == $past(stack_pointer_reg_o)
                    && stack_pointer_reg_o == $past(stack_pointer_reg_o) + 16'h0002)
        else $error("push did not write then step pointer up");

    AST_POP_STEP: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE2
        is_pop |=> stack_pointer_reg_o == $past(stack_pointer_reg_o) - 16'h0002
                   && resp_o.effective_address == stack_pointer_reg_o)
        else $error("pop did not step pointer down before reading");

    AST_CALL_MSB: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE3
        req_i.valid && req_i.op == scag_pkg::OP_CALL_PUSH |=> resp_o.wdata[15:8] == 8'h00
            && resp_o.wdata[7:0] == $past(req_i.pc_upper[7:0]))
        else $error("call push high byte not clear");

    AST_EXC_SRL: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE4
        req_i.valid && req_i.op == scag_pkg::OP_EXC_PUSH |=> resp_o.wdata[15:8] == $past(req_i.status_low_byte))
        else $error("exception push lacks status byte");

    AST_LIMIT_ALIGN: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE5
        req_i.valid && req_i.op == scag_pkg::OP_WR_LIMIT |=> st.stack_upper_limit[0] == 1'b0
            && st.stack_upper_limit[15:1] == $past(req_i.wdata[15:1]))
        else $error("limit not word aligned");

    AST_LIMIT_TRAP: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE6
        push_at_limit |=> !resp_o.stack_over)
        else $error("push at limit trapped");

    AST_OVER_TRAP: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE6 see RULE21
        push_past_limit |=> resp_o.valid && resp_o.stack_over)
        else $error("push past limit did not trap");

    AST_UNDERFLOW: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE7
        is_pop && stack_pointer_reg_o < 16'h0802 |=> resp_o.stack_under)
        else $error("underflow not flagged");

    AST_SECURE: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE9
        req_i.valid && prot_i.boot_ram_en && prot_i.code_seg != scag_pkg::SEG_BOOT
            && req_i.op == scag_pkg::OP_FILE && req_i.move_instr
            && req_i.full_addr inside {[scag_pkg::BOOT_RAM_LO:scag_pkg::BOOT_RAM_HI]}
        |=> !resp_o.rd && !resp_o.wr && resp_o.prot_fault)
        else $error("boot ram reached from foreign code");

    AST_NEAR_FILE: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE10
        req_i.valid && req_i.op == scag_pkg::OP_FILE && !req_i.move_instr
        |=> resp_o.effective_address == {3'h0, $past(req_i.file_addr)})
        else $error("file address not limited to near space");

    AST_POST_MOD: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE15
        req_i.valid && req_i.op == scag_pkg::OP_POST
        |=> resp_o.effective_address == $past(st.default_working_reg[req_i.pointer_reg])
            && st.default_working_reg[$past(req_i.pointer_reg)] == $past(st.default_working_reg[req_i.pointer_reg]) + $past(req_i.offset))
        else $error("post-modify wrong");

    AST_PRE_MOD: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE16
        req_i.valid && req_i.op == scag_pkg::OP_PRE
        |=> resp_o.effective_address == st.default_working_reg[$past(req_i.pointer_reg)])
        else $error("pre-modify address differs from pointer");

    AST_INDEXED: assert property (@(posedge clock_i) disable iff (rst_i) // see RULE17
        req_i.valid && req_i.op == scag_pkg::OP_INDEXED
        |=> resp_o.effective_address
            == $past(st.default_working_reg[req_i.pointer_reg]) + $past(st.default_working_reg[req_i.base_operand_reg]))
        else $error("indexed address wrong");

endmodule

/* hw/scag_pkg.sv */
// scag_pkg: constants, enums and carrier structs for the stack-check and address generator
// assumes one 40 MHz core clock; decoder and memory sit outside the block
package scag_pkg;

    // ==================================================
    // clock and geometry
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned NUM_DEFAULT_WORKING_REG      = 16;
    localparam int unsigned FILE_ADDR_W   = 13;
    localparam logic [3:0]  SP_INDEX      = 4'hF;
    localparam logic [3:0]  DEFAULT_DEFAULT_WORKING_REG  = 4'h0;

    // ==================================================
    // reset values, stack bounds
    localparam logic [15:0] SP_RESET      = 16'h0800;
    localparam logic [15:0] STACK_FLOOR   = 16'h0800;
    localparam logic [15:0] STACK_STEP    = 16'h0002;
    localparam logic [15:0] WORD_MASK     = 16'hFFFE;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;

    // ==================================================
    // secure ram segment bounds
    localparam logic [15:0] BOOT_RAM_LO   = 16'h0800;
    localparam logic [15:0] BOOT_RAM_HI   = 16'h08FF;
    localparam logic [15:0] SEC_RAM_LO    = 16'h0900;
    localparam logic [15:0] SEC_RAM_HI    = 16'h09FF;

    // ==================================================
    // operations
    typedef enum logic [3:0] {
        OP_FILE       = 4'h0,
        OP_REG_DIRECT = 4'h1,
        OP_IND        = 4'h2,
        OP_POST       = 4'h3,
        OP_PRE        = 4'h4,
        OP_INDEXED    = 4'h5,
        OP_LIT_OFFSET = 4'h6,
        OP_LITERAL    = 4'h7,
        OP_PUSH       = 4'h8,
        OP_POP        = 4'h9,
        OP_CALL_PUSH  = 4'hA,
        OP_EXC_PUSH   = 4'hB,
        OP_WR_LIMIT   = 4'hC,
        OP_WR_REG     = 4'hD
    } scag_op_t;

    typedef enum logic [1:0] {
        LIT_5  = 2'h0,
        LIT_8  = 2'h1,
        LIT_10 = 2'h2,
        LIT_16 = 2'h3
    } scag_lit_t;

    typedef enum logic [1:0] {
        DEST_FILE     = 2'h0,
        DEST_DEFAULT_WORKING_REG     = 2'h1,
        DEST_REG      = 2'h2,
        DEST_REG_PAIR = 2'h3
    } scag_dest_t;

    typedef enum logic [1:0] {
        SEG_USER = 2'h0,
        SEG_BOOT = 2'h1,
        SEG_SEC  = 2'h2
    } scag_seg_t;

    // ==================================================
    // carriers
    typedef struct packed {
        logic             valid;
        scag_op_t         op;
        logic             is_write;
        logic             move_instr;
        logic             multiply_instr;
        logic             to_default_working_reg;
        logic [3:0]       pointer_reg;
        logic [3:0]       base_operand_reg;
        logic [15:0]      offset;
        logic [12:0]      file_addr;
        logic [15:0]      full_addr;
        scag_lit_t        lit_kind;
        logic [15:0]      literal;
        logic [15:0]      wdata;
        logic [15:0]      pc_upper;
        logic [7:0]       status_low_byte;
    } scag_req_t;

    typedef struct packed {
        logic             boot_ram_en;
        logic             sec_ram_en;
        scag_seg_t        code_seg;
    } scag_prot_t;

    typedef struct packed {
        logic             valid;
        logic             rd;
        logic             wr;
        logic [15:0]      effective_address;
        logic [15:0]      wdata;
        logic [15:0]      operand;
        logic [3:0]       op1_reg;
        scag_dest_t       dest;
        logic             stack_over;
        logic             stack_under;
        logic             prot_fault;
    } scag_resp_t;

endpackage

/* tb/scag_partner.sv */
// scag_partner: behavioural decoder and trap side facing scag_core
// assumes bench hands one command per go pulse; answers are captured for the bench
`timescale 1ns/100ps
module scag_partner (
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    input  wire scag_pkg::scag_req_t  cmd_i,
    input  wire logic                 go_i,
    output scag_pkg::scag_req_t       req_o,
    input  wire scag_pkg::scag_resp_t resp_i,
    output scag_pkg::scag_resp_t      seen_o,
    output logic                      seen_valid_o,
    output logic [7:0]                trap_count_o
);
    // ==================================================
    // request issue and answer capture
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            req_o        <= '0;
            seen_o       <= '0;
            seen_valid_o <= 1'b0;
            trap_count_o <= 8'h00;
        end else begin
            // one request per go pulse, idle request between
            req_o        <= go_i ? cmd_i : '0;
            seen_valid_o <= resp_i.valid;
            if (resp_i.valid) begin
                seen_o <= resp_i;
            end
            // trap requests counted as the trap logic would take them
            if (resp_i.valid && (resp_i.stack_over || resp_i.stack_under)) begin
                trap_count_o <= trap_count_o + 8'h01;
            end
        end
    end
endmodule

/* tb/tb.sv */
// tb: self-checking bench for scag_core
// assumes scag_partner issues requests; bench drives commands and protection
`timescale 1ns/100ps
module tb;
    logic                 clock_i;
    logic                 rst_i;
    scag_pkg::scag_req_t  cmd;
    logic                 go;
    scag_pkg::scag_req_t  req;
    scag_pkg::scag_prot_t prot;
    scag_pkg::scag_resp_t resp;
    scag_pkg::scag_resp_t seen;
    logic                 seen_valid;
    logic [7:0]           traps;
    logic [15:0]          sp;
    int                   bad_count;
    int                   tests_run;

    // ==================================================
    // instances
    scag_core dut_u (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .prot_i(prot), .resp_o(resp),
                     .stack_pointer_reg_o(sp));
    scag_partner partner_u (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd), .go_i(go), .req_o(req),
                            .resp_i(resp), .seen_o(seen), .seen_valid_o(seen_valid), .trap_count_o(traps));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // ==================================================
    // helpers
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic scag_pkg::scag_req_t mk(input scag_pkg::scag_op_t op, input logic [3:0] ptr,
                                               input logic [15:0] off, input logic [15:0] wd);
        scag_pkg::scag_req_t r;
        r             = '0;
        r.valid       = 1'b1;
        r.op          = op;
        r.pointer_reg = ptr;
        r.offset      = off;
        r.wdata       = wd;
        return r;
    endfunction

    task automatic run(input scag_pkg::scag_req_t r);
        bit got;
        got = 0;
        @(posedge clock_i);
        cmd <= r;
        go  <= 1'b1;
        @(posedge clock_i);
        go  <= 1'b0;
        for (int i = 0; i < 10 && !got; i++) begin
            @(posedge clock_i);
            #1;
            got = (seen_valid === 1'b1);
        end
        if (!got) begin
            bad_count++;
            $display("[ERR] answer expected 1 seen 0");
            test_done();
        end
    endtask

    // ==================================================
    // scenarios
    task automatic t_stack();
        run(mk(scag_pkg::OP_WR_LIMIT, 4'hF, 16'h0000, 16'h0803));
        run(mk(scag_pkg::OP_PUSH, 4'hF, 16'h0000, 16'h1111));
        check("push ea", seen.effective_address, 16'h0800);
        check("push wr", {15'h0, seen.wr}, 16'h0001);
        check("sp after push", sp, 16'h0802);
        run(mk(scag_pkg::OP_PUSH, 4'hF, 16'h0000, 16'h2222));
        check("push at limit", {15'h0, seen.stack_over}, 16'h0000);
        run(mk(scag_pkg::OP_PUSH, 4'hF, 16'h0000, 16'h3333));
        check("push past limit", {15'h0, seen.stack_over}, 16'h0001);
        check("past limit ea", seen.effective_address, 16'h0804);
        run(mk(scag_pkg::OP_POP, 4'hF, 16'h0000, 16'h0000));
        check("pop ea", seen.effective_address, 16'h0804);
        check("pop rd", {15'h0, seen.rd}, 16'h0001);
        check("sp after pop", sp, 16'h0804);
        check("pop over", {15'h0, seen.stack_over}, 16'h0001);
        run(mk(scag_pkg::OP_POP, 4'hF, 16'h0000, 16'h0000));
        run(mk(scag_pkg::OP_POP, 4'hF, 16'h0000, 16'h0000));
        check("pop floor ea", seen.effective_address, 16'h0800);
        check("pop floor under", {15'h0, seen.stack_under}, 16'h0000);
        run(mk(scag_pkg::OP_POP, 4'hF, 16'h0000, 16'h0000));
        check("pop under ea", seen.effective_address, 16'h07FE);
        check("pop under", {15'h0, seen.stack_under}, 16'h0001);
        run(mk(scag_pkg::OP_PUSH, 4'hF, 16'h0000, 16'h4444));
        check("push under", {15'h0, seen.stack_under}, 16'h0001);
        check("sp restored", sp, 16'h0800);
        check("trap count", {8'h00, traps}, 16'h0004);
    endtask

    task automatic t_frames();
        scag_pkg::scag_req_t r;
        r          = mk(scag_pkg::OP_CALL_PUSH, 4'hF, 16'h0000, 16'h0000);
        r.pc_upper = 16'hABCD;
        run(r);
        check("call word", seen.wdata, 16'h00CD);
        r                 = mk(scag_pkg::OP_EXC_PUSH, 4'hF, 16'h0000, 16'h0000);
        r.pc_upper        = 16'h12CD;
        r.status_low_byte = 8'h5A;
        run(r);
        check("exc word", seen.wdata, 16'h5ACD);
        check("exc ea", seen.effective_address, 16'h0802);
    endtask

    task automatic t_modes();
        scag_pkg::scag_req_t r;
        run(mk(scag_pkg::OP_WR_REG, 4'h3, 16'h0000, 16'h1000));
        run(mk(scag_pkg::OP_WR_REG, 4'h4, 16'h0000, 16'h0010));
        run(mk(scag_pkg::OP_IND, 4'h3, 16'h0000, 16'h0000));
        check("ind ea", seen.effective_address, 16'h1000);
        run(mk(scag_pkg::OP_POST, 4'h3, 16'h0002, 16'h0000));
        check("post ea", seen.effective_address, 16'h1000);
        run(mk(scag_pkg::OP_IND, 4'h3, 16'h0000, 16'h0000));
        check("post step", seen.effective_address, 16'h1002);
        run(mk(scag_pkg::OP_PRE, 4'h3, 16'hFFFE, 16'h0000));
        check("pre ea", seen.effective_address, 16'h1000);
        r                  = mk(scag_pkg::OP_INDEXED, 4'h3, 16'h0000, 16'h0000);
        r.base_operand_reg = 4'h4;
        run(r);
        check("indexed ea", seen.effective_address, 16'h1010);
        check("first operand", {12'h000, seen.op1_reg}, 16'h0004);
        run(mk(scag_pkg::OP_LIT_OFFSET, 4'h3, 16'h0020, 16'h0000));
        check("lit offset ea", seen.effective_address, 16'h1020);
        run(mk(scag_pkg::OP_REG_DIRECT, 4'h3, 16'h0000, 16'h0000));
        check("direct operand", seen.operand, 16'h1000);
    endtask

    task automatic t_file();
        scag_pkg::scag_req_t r;
        r           = mk(scag_pkg::OP_FILE, 4'h0, 16'h0000, 16'h0000);
        r.file_addr = 13'h1FFF;
        r.full_addr = 16'hE000;
        r.to_default_working_reg   = 1'b1;
        run(r);
        check("file ea", seen.effective_address, 16'h1FFF);
        check("file dest", {14'h0, seen.dest}, {14'h0, scag_pkg::DEST_DEFAULT_WORKING_REG});
        r.to_default_working_reg        = 1'b0;
        r.multiply_instr = 1'b1;
        run(r);
        check("mul dest", {14'h0, seen.dest}, {14'h0, scag_pkg::DEST_REG_PAIR});
        r.multiply_instr = 1'b0;
        r.move_instr     = 1'b1;
        r.full_addr      = 16'hC000;
        run(r);
        check("move ea", seen.effective_address, 16'hC000);
    endtask

    task automatic t_literals();
        scag_pkg::scag_req_t r;
        logic [15:0]         exp [4];
        exp = '{16'h001F, 16'h00FF, 16'h03FF, 16'hFFFF};
        for (int k = 0; k < 4; k++) begin
            r          = mk(scag_pkg::OP_LITERAL, 4'h0, 16'h0000, 16'h0000);
            r.lit_kind = scag_pkg::scag_lit_t'(k);
            r.literal  = 16'hFFFF;
            run(r);
            check("literal", seen.operand, exp[k]);
        end
    endtask

    task automatic t_protect();
        scag_pkg::scag_req_t r;
        logic [15:0] addr [4];
        logic [1:0]  seg  [4];
        logic        ok   [4];
        addr = '{16'h0810, 16'h0810, 16'h0910, 16'h0910};
        seg  = '{2'h0, 2'h1, 2'h1, 2'h2};
        ok   = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_i);
            prot <= '{1'b1, 1'b1, scag_pkg::scag_seg_t'(seg[k])};
            run(mk(scag_pkg::OP_WR_REG, 4'h3, 16'h0000, addr[k]));
            run(mk(scag_pkg::OP_IND, 4'h3, 16'h0000, 16'h0000));
            check("prot fault", {15'h0, seen.prot_fault}, {15'h0, ~ok[k]});
            check("prot read", {15'h0, seen.rd}, {15'h0, ok[k]});
        end
        r            = mk(scag_pkg::OP_FILE, 4'h0, 16'h0000, 16'h0000);
        r.move_instr = 1'b1;
        r.full_addr  = 16'h0810;
        run(r);
        check("move prot", {15'h0, seen.prot_fault}, 16'h0001);
        check("move prot rd", {15'h0, seen.rd}, 16'h0000);
        @(posedge clock_i);
        prot <= '0;
    endtask

    // ==================================================
    // main sequence
    initial begin
        bad_count = 0;
        tests_run = 0;
        rst_i     = 1'b1;
        cmd       = '0;
        go        = 1'b0;
        prot      = '0;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        check("sp reset", sp, 16'h0800);
        check("resp reset", {15'h0, resp.valid}, 16'h0000);
        t_stack();
        t_frames();
        t_modes();
        t_file();
        t_literals();
        t_protect();
        test_done();
    end
endmodule
